// ===== tgrp_pkg.sv
package tgrp_pkg;

    localparam int unsigned CNT_W      = 16;
    localparam int unsigned PRE_W      = 3;
    // finest resolution: one count per 4 system clocks
    localparam int unsigned BASE_DIV   = 4;
    localparam int unsigned BASE_CNT_W = 2;
    localparam int unsigned PRE_CNT_W  = 10;

    localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

    // operating modes
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_GATED = 2'h1;
    localparam logic [1:0] MODE_COUNT = 2'h2;
    localparam logic [1:0] MODE_ENC   = 2'h3;

    // clock source for the auxiliary timers
    localparam logic [1:0] SRC_OWN    = 2'h0;
    localparam logic [1:0] SRC_LATCH  = 2'h1;
    localparam logic [1:0] SRC_CHAIN  = 2'h2;

    // lower aux role
    localparam logic [1:0] ROLE_TIMER   = 2'h0;
    localparam logic [1:0] ROLE_CAPTURE = 2'h1;
    localparam logic [1:0] ROLE_RELOAD  = 2'h2;

    // edge select for count, capture and reload triggers
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef struct packed {
        logic       run;
        logic [1:0] mode;
        logic [PRE_W-1:0] prescale;
        logic       dir_down;
        logic       ext_dir_en;
        logic       gate_high;
        logic [1:0] edge_sel;
        logic [1:0] src;
    } tgrp_cfg_t;

    typedef struct packed {
        logic in_pin;
        logic dir_pin;
    } tgrp_pins_t;

    typedef struct packed {
        logic [1:0] role;
        logic [1:0] trig_edge;
        logic       reload_on_latch;
        logic [1:0] latch_edge;
    } tgrp_role_t;

endpackage : tgrp_pkg

// ===== tgrp_three_timer_module.sv
`timescale 1ns/1ps
// Overview of operation
// R1: every timer holds a 16-bit count; this is the three-timer module.
// R2: a timer may run alone or be chained to another for a longer count.
// R3: each timer picks timer, gated timer, event counter or encoder mode.
// R4: timer mode counts the system clock through a programmable prescaler.
// R5: counter mode counts external edges on the timer input pin.
// R6: gated mode counts prescaled clock only while the gate pin is active.
// R7: fastest count rate is one step per 4 system clocks.
// R8: direction set by software or switched by the direction pin.
// R9: encoder mode derives count and direction from phases A and B.
// R10: upper aux timer has no pins; internal sources still work.
// R11: core toggle latch inverts on every core overflow or underflow.
// R12: toggle latch state can drive a dedicated output pin.
// R13: toggle latch can clock both auxiliary timers.
// R14: lower aux timer can be capture or reload register and then stops.
// R15: capture copies core count into lower aux on its input pin event.
// R16: reload loads core from lower aux on pin event or latch transition.
// R17: overflow, underflow, capture and reload raise clearable request flags.
// R18: external pins are synchronised and edge detected before use.
module tgrp_three_timer_module #(
    parameter int unsigned CNT_W = tgrp_pkg::CNT_W
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire tgrp_pkg::tgrp_cfg_t  core_cfg,
    input  wire tgrp_pkg::tgrp_cfg_t  low_cfg,
    input  wire tgrp_pkg::tgrp_cfg_t  up_cfg,
    input  wire tgrp_pkg::tgrp_role_t low_role,
    input  wire logic                 latch_out_en,
    input  wire tgrp_pkg::tgrp_pins_t core_pins,
    input  wire tgrp_pkg::tgrp_pins_t low_pins,
    input  wire logic [2:0]           req_clr,
    input  wire logic                 cap_clr,
    output logic [CNT_W-1:0]          core_count,
    output logic [CNT_W-1:0]          low_count,
    output logic [CNT_W-1:0]          up_count,
    output logic                      core_toggle_latch,
    output logic                      toggle_latch_output_pin,
    output logic [2:0]                wrap_req,
    output logic                      cap_req
);

    logic [1:0] rst_sync_q;
    logic [1:0] rst_sync_d;
    logic       rst_n;

    // reset enters at once but leaves in step with the clock
    always_comb begin
        rst_sync_d = {rst_sync_q[0], 1'b1};
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end
    assign rst_n = rst_sync_q[1];

    // two-stage sync then one history flop per pin
    logic [3:0] pin_raw;
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic [3:0] hist_q;
    logic [3:0] meta_d;
    logic [3:0] sync_d;
    logic [3:0] hist_d;

    assign pin_raw = {low_pins.dir_pin, low_pins.in_pin, core_pins.dir_pin, core_pins.in_pin};

    always_comb begin
        meta_d = pin_raw;                                                      // R18
        sync_d = meta_q;
        hist_d = sync_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
            hist_q <= 4'h0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            hist_q <= hist_d;
        end
    end

    function automatic logic edge_hit(input logic now, input logic old, input logic [1:0] sel);
        edge_hit = (sel[0] && now && !old) || (sel[1] && !now && old);
    endfunction : edge_hit

    // prescaler: base tick every 4 clocks, then divided by 2**prescale
    logic [tgrp_pkg::BASE_CNT_W-1:0] base_q;
    logic [tgrp_pkg::BASE_CNT_W-1:0] base_d;
    logic [tgrp_pkg::PRE_CNT_W-1:0]  pre_q;
    logic [tgrp_pkg::PRE_CNT_W-1:0]  pre_d;
    logic                            base_tick;

    always_comb begin
        base_d = base_q + 2'h1;                                                // R7
        base_tick = (base_q == tgrp_pkg::BASE_CNT_W'(tgrp_pkg::BASE_DIV - 1));
        pre_d = base_tick ? pre_q + 10'h001 : pre_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_q <= 2'h0;
            pre_q  <= 10'h000;
        end else begin
            base_q <= base_d;
            pre_q  <= pre_d;
        end
    end

    // prescaled tick: base tick when all low prescaler bits are set
    function automatic logic pre_tick(input logic [tgrp_pkg::PRE_W-1:0] ps);
        logic [tgrp_pkg::PRE_CNT_W-1:0] mask;
        mask = (10'h001 << ps) - 10'h001;
        pre_tick = base_tick && ((pre_q & mask) == mask);                      // R4
    endfunction : pre_tick

    // one timer's step decision; returns {step, down}
    function automatic logic [1:0] step_of(input tgrp_pkg::tgrp_cfg_t c,
                                           input logic in_now, input logic in_old,
                                           input logic dir_now, input logic dir_old,
                                           input logic has_pins, input logic int_tick);
        logic st;
        logic dn;
        st = 1'b0;
        dn = c.dir_down ^ (c.ext_dir_en && has_pins && dir_now);               // R8
        case (c.mode)
            tgrp_pkg::MODE_TIMER: st = pre_tick(c.prescale);                   // R4
            tgrp_pkg::MODE_GATED:
                st = pre_tick(c.prescale) && has_pins && (in_now == c.gate_high); // R6
            tgrp_pkg::MODE_COUNT: st = has_pins && edge_hit(in_now, in_old, c.edge_sel); // R5
            tgrp_pkg::MODE_ENC: begin
                // any phase edge steps; direction from phase relation
                st = has_pins && ((in_now ^ in_old) || (dir_now ^ dir_old));   // R9
                dn = (in_now ^ in_old) ? (in_now == dir_now) : (in_now != dir_now); // R9
                dn = dn ^ c.dir_down;
            end
            default: st = 1'b0;
        endcase
        if (c.src != tgrp_pkg::SRC_OWN) begin
            st = int_tick;                                                     // R2
        end
        step_of = {st && c.run, dn};
    endfunction : step_of

    function automatic logic [CNT_W:0] advance(input logic [CNT_W-1:0] v, input logic dn);
        logic wrap;
        wrap = dn ? (v == CNT_W'(tgrp_pkg::CNT_RST)) : (v == CNT_W'(tgrp_pkg::CNT_MAX));
        advance = {wrap, dn ? v - CNT_W'(tgrp_pkg::CNT_ONE) : v + CNT_W'(tgrp_pkg::CNT_ONE)};
    endfunction : advance

    // synchronised levels and their one-cycle history, per pin
    logic             core_in_now;
    logic             core_in_old;
    logic             core_dir_now;
    logic             core_dir_old;
    logic             low_in_now;
    logic             low_in_old;
    logic             low_dir_now;
    logic             low_dir_old;

    assign core_in_now  = sync_q[0];
    assign core_in_old  = hist_q[0];
    assign core_dir_now = sync_q[1];
    assign core_dir_old = hist_q[1];
    assign low_in_now   = sync_q[2];
    assign low_in_old   = hist_q[2];
    assign low_dir_now  = sync_q[3];
    assign low_dir_old  = hist_q[3];

    // counter state and per-timer step results
    logic [CNT_W-1:0] core_q;
    logic [CNT_W-1:0] core_d;
    logic [CNT_W-1:0] low_q;
    logic [CNT_W-1:0] low_d;
    logic [CNT_W-1:0] up_q;
    logic [CNT_W-1:0] up_d;
    logic             latch_q;
    logic             latch_d;
    logic [2:0]       req_q;
    logic [2:0]       req_d;
    logic             cap_q;
    logic             cap_d;
    logic [1:0]       core_st;
    logic [1:0]       low_st;
    logic [1:0]       up_st;
    logic [CNT_W:0]   core_nx;
    logic [CNT_W:0]   low_nx;
    logic [CNT_W:0]   up_nx;
    logic             core_wrap;
    logic             low_wrap;
    logic             up_wrap;
    logic             latch_rise;
    logic             latch_fall;
    logic             latch_tick;
    logic             low_trig;
    logic             reload_hit;
    logic             aux_stopped;

    // core timer and its toggle latch
    always_comb begin
        core_st    = step_of(core_cfg, core_in_now, core_in_old, core_dir_now, core_dir_old,
                             1'b1, 1'b0);
        core_nx    = advance(core_q, core_st[0]);
        core_wrap  = core_st[1] && core_nx[CNT_W];
        latch_d    = latch_q ^ core_wrap;                                      // R11
        latch_rise = !latch_q && latch_d;
        latch_fall = latch_q && !latch_d;
        latch_tick = latch_rise || latch_fall;
        low_trig   = edge_hit(low_in_now, low_in_old, low_role.trig_edge);
        reload_hit = (low_role.role == tgrp_pkg::ROLE_RELOAD) &&
                     (low_role.reload_on_latch ?
                      edge_hit(latch_d, latch_q, low_role.latch_edge) : low_trig);
        core_d     = core_st[1] ? core_nx[CNT_W-1:0] : core_q;                 // R1
        // a reload wins over a step in the same cycle
        if (reload_hit) begin
            core_d = low_q;                                                    // R16
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_q  <= tgrp_pkg::CNT_RST;
            latch_q <= 1'b0;
        end else begin
            core_q  <= core_d;
            latch_q <= latch_d;
        end
    end

    // lower aux: counts, or holds a capture or reload value
    always_comb begin
        aux_stopped = (low_role.role != tgrp_pkg::ROLE_TIMER);                 // R14
        low_st      = step_of(low_cfg, low_in_now, low_in_old, low_dir_now, low_dir_old, 1'b1,
                              (low_cfg.src == tgrp_pkg::SRC_LATCH) ?
                              latch_tick :                                     // R13
                              core_wrap);                                      // R2
        low_nx      = advance(low_q, low_st[0]);
        low_wrap    = low_st[1] && !aux_stopped && low_nx[CNT_W];
        low_d       = (low_st[1] && !aux_stopped) ? low_nx[CNT_W-1:0] : low_q; // R14
        if (low_role.role == tgrp_pkg::ROLE_CAPTURE && low_trig) begin
            low_d = core_q;                                                    // R15
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= tgrp_pkg::CNT_RST;
        end else begin
            low_q <= low_d;
        end
    end

    // upper aux has no pins: only its prescaled clock, the latch or chaining can step it
    always_comb begin
        up_st   = step_of(up_cfg, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,                // R10
                          (up_cfg.src == tgrp_pkg::SRC_LATCH) ?
                          latch_tick :                                         // R13
                          core_wrap);
        up_nx   = advance(up_q, up_st[0]);
        up_wrap = up_st[1] && up_nx[CNT_W];
        up_d    = up_st[1] ? up_nx[CNT_W-1:0] : up_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= tgrp_pkg::CNT_RST;
        end else begin
            up_q <= up_d;
        end
    end

    // request flags: set beats clear so an event in the clear cycle is kept
    always_comb begin
        cap_d = cap_q && !cap_clr;
        if ((low_role.role == tgrp_pkg::ROLE_CAPTURE && low_trig) || reload_hit) begin
            cap_d = 1'b1;                                                      // R17
        end
        req_d = (req_q & ~req_clr) | {up_wrap, low_wrap, core_wrap};           // R17
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 3'h0;
            cap_q <= 1'b0;
        end else begin
            req_q <= req_d;
            cap_q <= cap_d;
        end
    end

    assign core_count              = core_q;
    assign low_count               = low_q;
    assign up_count                = up_q;
    assign core_toggle_latch       = latch_q;
    assign toggle_latch_output_pin = latch_out_en & latch_q;                   // R12
    assign wrap_req                = req_q;
    assign cap_req                 = cap_q;

endmodule : tgrp_three_timer_module

// ===== tgrp_pins_model.sv
`timescale 1ns/1ps
module tgrp_pins_model (
    input  wire logic           ref_clk,
    input  wire logic           fwd,
    input  wire logic           back,
    input  wire logic           pulse,
    output tgrp_pkg::tgrp_pins_t core_pins,
    output tgrp_pkg::tgrp_pins_t low_pins
);
    logic [1:0] phase_q = 2'h0;
    logic [1:0] phase_d;
    logic       pulse_q = 1'b0;
    // fwd adds one, back subtracts one, both low holds the phase
    always_comb begin
        phase_d = phase_q + {back, fwd | back};
    end
    always_ff @(posedge ref_clk) begin
        phase_q <= phase_d;
        pulse_q <= pulse;
    end
    // gray sequence on A and B, a single line changes per step
    assign core_pins = '{phase_q[1], phase_q[1] ^ phase_q[0]};
    // no pins exist for the upper aux timer
    assign low_pins = '{pulse_q, 1'b0};
endmodule : tgrp_pins_model

// ===== tgrp_three_timer_module_chk.sv
`timescale 1ns/1ps
module tgrp_chk #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic                 ref_clk,
    input wire logic                 rstn,
    input wire tgrp_pkg::tgrp_cfg_t  core_cfg,
    input wire tgrp_pkg::tgrp_role_t low_role,
    input wire logic                 latch_out_en,
    input wire tgrp_pkg::tgrp_pins_t core_pins,
    input wire logic [2:0]           req_clr,
    input wire logic [CNT_W-1:0]     core_count,
    input wire logic [CNT_W-1:0]     low_count,
    input wire logic                 core_toggle_latch,
    input wire logic                 toggle_latch_output_pin,
    input wire logic [2:0]           wrap_req,
    input wire logic                 cap_req
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    sequence gate_shut_s;
        (core_cfg.mode == tgrp_pkg::MODE_GATED && core_cfg.gate_high && !core_pins.in_pin)[*5];
    endsequence
    sequence latch_flip_s;
        $changed(core_toggle_latch);
    endsequence
    AST_GATE: assert property (gate_shut_s |=> $stable(core_count))
        else $error("core counted with gate closed");
    AST_LATCH: assert property (latch_flip_s |->
        ($past(core_count) == '1 && core_count == '0) || ($past(core_count) == '0 && core_count == '1))
        else $error("latch flipped without wrap");
    AST_WRAP_SET: assert property (latch_flip_s |-> wrap_req[0])
        else $error("wrap flag missing");
    AST_PIN: assert property (toggle_latch_output_pin == (core_toggle_latch && latch_out_en))
        else $error("output pin wrong");
    AST_RES: assert property ($changed(core_count) && core_cfg.mode == tgrp_pkg::MODE_TIMER
        && low_role.role == tgrp_pkg::ROLE_TIMER |=> $stable(core_count)[*3])
        else $error("core stepped faster than base tick");
    AST_STOP: assert property (low_role.role == tgrp_pkg::ROLE_RELOAD
        && $past(low_role.role) == tgrp_pkg::ROLE_RELOAD |-> $stable(low_count))
        else $error("lower aux counted as reload register");
    AST_CAP: assert property ($changed(low_count) && low_role.role == tgrp_pkg::ROLE_CAPTURE
        |-> cap_req) else $error("capture without flag");
    AST_STICKY: assert property (wrap_req[0] && !req_clr[0] |=> wrap_req[0])
        else $error("wrap flag lost");
    AST_STEP: assert property ($changed(core_count) && low_role.role != tgrp_pkg::ROLE_RELOAD
        && $past(low_role.role) != tgrp_pkg::ROLE_RELOAD |->
        core_count == $past(core_count) + 1'b1 || core_count == $past(core_count) - 1'b1)
        else $error("core jumped by more than one");
endmodule : tgrp_chk
bind tgrp_three_timer_module tgrp_chk #(.CNT_W(CNT_W)) i_chk (
    .ref_clk(ref_clk), .rstn(rstn), .core_cfg(core_cfg), .low_role(low_role),
    .latch_out_en(latch_out_en), .core_pins(core_pins), .req_clr(req_clr),
    .core_count(core_count), .low_count(low_count), .core_toggle_latch(core_toggle_latch),
    .toggle_latch_output_pin(toggle_latch_output_pin), .wrap_req(wrap_req), .cap_req(cap_req)
);

// ===== tgrp_three_timer_module_bench.sv
`timescale 1ns/1ps
module tgrp_three_timer_module_bench;
    logic                 ref_clk = 1'b0;
    logic                 rstn = 1'b0;
    tgrp_pkg::tgrp_cfg_t  core_cfg, low_cfg, up_cfg;
    tgrp_pkg::tgrp_role_t low_role;
    tgrp_pkg::tgrp_pins_t core_pins, low_pins;
    logic                 latch_out_en, cap_clr, fwd, back, pulse, core_toggle_latch, pin, cap_req;
    logic [2:0]           req_clr, wrap_req;
    logic [15:0]          core_count, low_count, up_count, v, d;
    int                   fails = 0, cmp_count = 0, cycles = 0;

    always #5 ref_clk = ~ref_clk;

    tgrp_pins_model i_pins (.ref_clk(ref_clk), .fwd(fwd), .back(back), .pulse(pulse),
                            .core_pins(core_pins), .low_pins(low_pins));
    tgrp_three_timer_module i_dut (.ref_clk(ref_clk), .rstn(rstn), .core_cfg(core_cfg),
        .low_cfg(low_cfg), .up_cfg(up_cfg), .low_role(low_role), .latch_out_en(latch_out_en),
        .core_pins(core_pins), .low_pins(low_pins), .req_clr(req_clr), .cap_clr(cap_clr),
        .core_count(core_count), .low_count(low_count), .up_count(up_count),
        .core_toggle_latch(core_toggle_latch), .toggle_latch_output_pin(pin),
        .wrap_req(wrap_req), .cap_req(cap_req));

    function automatic tgrp_pkg::tgrp_cfg_t mk(input logic run, input logic [1:0] mode,
                                               input logic dn, input logic [1:0] src);
        mk = '{run, mode, 3'h0, dn, 1'b0, 1'b1, tgrp_pkg::EDGE_BOTH, src};
    endfunction : mk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input logic dn);
        fwd = ~dn;
        back = dn;
        tick(1);
        fwd = 1'b0;
        back = 1'b0;
        tick(5);
    endtask : step

    task automatic end_of_test;
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // whole sequence needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        core_cfg = mk(1'b0, tgrp_pkg::MODE_TIMER, 1'b1, tgrp_pkg::SRC_OWN);
        low_cfg = mk(1'b1, tgrp_pkg::MODE_TIMER, 1'b0, tgrp_pkg::SRC_CHAIN);
        up_cfg = mk(1'b1, tgrp_pkg::MODE_TIMER, 1'b0, tgrp_pkg::SRC_LATCH);
        low_role = '0;
        {latch_out_en, cap_clr, fwd, back, pulse, req_clr} = 8'h80;
        tick(4);
        rstn = 1'b1;
        tick(4);
        core_cfg.run = 1'b1;
        tick(8);
        check(16'(core_toggle_latch), 16'h0001);
        check(16'(wrap_req), 16'h0001);
        check(16'(pin), 16'h0001);
        check(low_count, 16'h0001);
        check(up_count, 16'h0001);
        v = core_count;
        tick(40);
        check(v - core_count, 16'h000a);
        latch_out_en = 1'b0;
        req_clr = 3'h1;
        tick(1);
        req_clr = 3'h0;
        check(16'(pin), 16'h0000);
        check(16'(wrap_req), 16'h0000);
        core_cfg = mk(1'b1, tgrp_pkg::MODE_GATED, 1'b1, tgrp_pkg::SRC_OWN);
        tick(8);
        v = core_count;
        tick(40);
        check(core_count, v);
        core_cfg.gate_high = 1'b0;
        tick(8);
        v = core_count;
        tick(40);
        check(v - core_count, 16'h000a);
        core_cfg = mk(1'b1, tgrp_pkg::MODE_ENC, 1'b0, tgrp_pkg::SRC_OWN);
        tick(8);
        v = core_count;
        repeat (4) step(1'b0);
        d = core_count - v;
        check(16'(d == 16'h0004 || d == 16'hfffc), 16'h0001);
        repeat (2) step(1'b1);
        check(core_count - v, (d == 16'h0004) ? 16'h0002 : 16'hfffe);
        v = low_count;
        low_cfg = mk(1'b1, tgrp_pkg::MODE_TIMER, 1'b0, tgrp_pkg::SRC_OWN);
        low_role = '{tgrp_pkg::ROLE_CAPTURE, tgrp_pkg::EDGE_RISE, 1'b0, 2'h0};
        step(1'b1);
        check(low_count, v);
        pulse = 1'b1;
        tick(6);
        check(low_count, core_count);
        check(16'(cap_req), 16'h0001);
        v = low_count;
        cap_clr = 1'b1;
        pulse = 1'b0;
        tick(1);
        cap_clr = 1'b0;
        check(16'(cap_req), 16'h0000);
        low_role.role = tgrp_pkg::ROLE_RELOAD;
        repeat (2) step(1'b0);
        pulse = 1'b1;
        tick(6);
        check(core_count, v);
        check(low_count, v);
        core_cfg = mk(1'b1, tgrp_pkg::MODE_COUNT, 1'b0, tgrp_pkg::SRC_OWN);
        v = core_count;
        repeat (4) step(1'b0);
        check(core_count - v, 16'h0002);
        core_cfg.ext_dir_en = 1'b1;
        v = core_count;
        repeat (4) step(1'b0);
        check(core_count - v, 16'h0000);
        core_cfg = mk(1'b1, tgrp_pkg::MODE_TIMER, 1'b0, tgrp_pkg::SRC_OWN);
        core_cfg.prescale = 3'h1;
        tick(8);
        v = core_count;
        tick(40);
        check(core_count - v, 16'h0005);
        end_of_test();
    end
endmodule : tgrp_three_timer_module_bench
